// >>> core/atat_core.sv
`timescale 1ns/1ps
// Summary of operation
// - each stage's offsets shift by the measured ambient drift
// - offset change recomputes that stage's upper and lower limits
// - one slow queue per stage tracks its ambient level
// - full-power skip field sits in bits 13:12 at ambient_skip_control
// - low-power skip field sits in bits 15:14, drops samples from slow queue
// - full-power slow queue period follows skip times sequence length, four sequences at 00
// - low-power slow queue period follows skip plus one times sequence length
// - sample admitted only if it differs from last by more than level
// - limits referenced to ambient; contact only when sample passes limit
// - limits are sensitivity fraction of offsets above or below ambient
// - software seeds offsets; engine then adapts limits itself
// - running average of maximum and minimum response kept per stage
// - change of average peak rescales the matching limit
// - 4-bit selection spans 25% to 95.3% of average peak
// - upper selection 1000 gives 62.5% of average peak
// - ambient compensation runs only on admitted conversions while untouched
// - ambient is untouched output from slow queue, used in both limits
// - sample within peak fraction of stored average updates that average
module atat_core #(
    parameter int STAGES = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire atat_pkg::atat_conv_t i_conv,
    output atat_pkg::atat_result_t o_result
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] sat16(input logic signed [19:0] v);
        if (v < 20'sd0) begin
            sat16 = 16'h0000;
        end else if (v > 20'sd65535) begin
            sat16 = 16'hffff;
        end else begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    // span/4 + 3/4 span * sel/16: 25% at 0000, 62.5% at 1000, 95.3% at 1111
    function automatic logic [15:0] limit_step(input logic [15:0] span,
                                               input logic [3:0] sel);
        logic [15:0] quarter;
        logic [19:0] rest;
        quarter = {2'b00, span[15:2]};
        // widen before the product, a 16-bit product would lose the top bits
        rest = 20'(span - quarter) * 20'(sel);
        limit_step = quarter + rest[19:4];
    endfunction : limit_step

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [15:0] skip_ctrl_ff;
    logic [15:0] ctrl_one_ff;
    logic [15:0] sens_cfg_ff;
    logic [15:0] mode_cfg_ff;
    logic [3:0] stage_sel_ff;
    logic [15:0] rdata_ff;

    wire logic [1:0] skip_fp = skip_ctrl_ff[atat_pkg::SKIP_FP_LSB +: 2];
    wire logic [1:0] skip_lp = skip_ctrl_ff[atat_pkg::SKIP_LP_LSB +: 2];
    wire logic [15:0] admit_level = ctrl_one_ff;
    wire logic [3:0] last_stage = sens_cfg_ff[atat_pkg::SENS_STAGES_LSB +: 4];
    wire logic [3:0] lower_sensitivity_sel = sens_cfg_ff[atat_pkg::SENS_LOWER_SEL_LSB +: 4];
    wire logic [3:0] upper_sensitivity_sel = sens_cfg_ff[atat_pkg::SENS_UPPER_SEL_LSB +: 4];
    wire logic [3:0] lower_peak_fraction = sens_cfg_ff[atat_pkg::SENS_LOWER_PEAK_LSB +: 4];
    wire logic [3:0] upper_peak_fraction = mode_cfg_ff[atat_pkg::MODE_UPPER_PEAK_LSB +: 4];
    wire logic low_power = mode_cfg_ff[atat_pkg::MODE_LOW_POWER_BIT];

    wire logic wr_skip = i_wr && (i_addr == atat_pkg::ADDR_SKIP_CTRL);
    wire logic wr_one = i_wr && (i_addr == atat_pkg::ADDR_CTRL_ONE);
    wire logic wr_sens = i_wr && (i_addr == atat_pkg::ADDR_SENS_CFG);
    wire logic wr_mode = i_wr && (i_addr == atat_pkg::ADDR_MODE_CFG);
    wire logic wr_sel = i_wr && (i_addr == atat_pkg::ADDR_STAGE_SEL);
    wire logic wr_uofs = i_wr && (i_addr == atat_pkg::ADDR_UPPER_OFS);
    wire logic wr_lofs = i_wr && (i_addr == atat_pkg::ADDR_LOWER_OFS);
    wire logic wr_amb = i_wr && (i_addr == atat_pkg::ADDR_AMBIENT);
    wire logic host_upd = wr_uofs || wr_lofs || wr_amb;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            skip_ctrl_ff <= atat_pkg::RST_SKIP_CTRL;
            ctrl_one_ff <= atat_pkg::RST_CTRL_ONE;
            sens_cfg_ff <= atat_pkg::RST_SENS_CFG;
            mode_cfg_ff <= atat_pkg::RST_MODE_CFG;
            stage_sel_ff <= 4'h0;
        end else begin
            if (wr_skip) begin
                skip_ctrl_ff <= i_wdata;
            end
            if (wr_one) begin
                ctrl_one_ff <= i_wdata;
            end
            if (wr_sens) begin
                sens_cfg_ff <= i_wdata;
            end
            if (wr_mode) begin
                mode_cfg_ff <= i_wdata;
            end
            if (wr_sel) begin
                stage_sel_ff <= i_wdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------
    // per-stage state, one shared datapath
    // ------------------------------------------------------------
    logic [15:0] ambient_ff [STAGES];
    logic [15:0] slow_last_ff [STAGES];
    logic [15:0] upper_ofs_ff [STAGES];
    logic [15:0] lower_ofs_ff [STAGES];
    logic [15:0] upper_lim_ff [STAGES];
    logic [15:0] lower_lim_ff [STAGES];

    // ------------------------------------------------------------
    // slow queue skip normalisation
    // ------------------------------------------------------------
    // counts whole sequences; with fp = 00 three sequences are skipped,
    // the period scales by the skip value as the update equations do
    logic [1:0] skip_cnt_ff;
    wire logic [1:0] skip_target = low_power ? skip_lp :
                                   (skip_fp == 2'h0) ? atat_pkg::FP_ZERO_SKIPS :
                                   2'(skip_fp - 2'h1);
    wire logic admit_window = (skip_cnt_ff == skip_target);
    wire logic seq_end = i_conv.valid && (i_conv.stage == last_stage);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            skip_cnt_ff <= 2'h0;
        end else if (seq_end) begin
            skip_cnt_ff <= admit_window ? 2'h0 : 2'(skip_cnt_ff + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // conversion datapath
    // ------------------------------------------------------------
    wire logic [3:0] cs = i_conv.stage;
    wire logic stage_ok = (32'(cs) < STAGES);
    wire logic [15:0] cur_amb = stage_ok ? ambient_ff[cs] : 16'h0000;
    wire logic [15:0] cur_last = stage_ok ? slow_last_ff[cs] : 16'h0000;
    wire logic [15:0] cur_uofs = stage_ok ? upper_ofs_ff[cs] : 16'h0000;
    wire logic [15:0] cur_lofs = stage_ok ? lower_ofs_ff[cs] : 16'h0000;
    wire logic [15:0] cur_ulim = stage_ok ? upper_lim_ff[cs] : 16'hffff;
    wire logic [15:0] cur_llim = stage_ok ? lower_lim_ff[cs] : 16'h0000;

    // contact only beyond a limit that already carries the ambient
    wire logic up_act = i_conv.value > cur_ulim;
    wire logic lo_act = i_conv.value < cur_llim;
    wire logic touched = up_act || lo_act;

    wire logic signed [19:0] diff_last = 20'(signed'({4'h0, i_conv.value}))
                                       - 20'(signed'({4'h0, cur_last}));
    wire logic [19:0] diff_abs = diff_last[19] ? 20'(-diff_last) : diff_last;
    wire logic admit = i_conv.valid && stage_ok && !touched && admit_window
                     && (diff_abs > {4'h0, admit_level});

    // slow filter step toward the sample; ambient is the untouched level
    wire logic signed [19:0] resp = 20'(signed'({4'h0, i_conv.value}))
                                  - 20'(signed'({4'h0, cur_amb}));
    wire logic signed [19:0] drift = admit ? (resp >>> atat_pkg::AMB_SHIFT) : 20'sd0;
    wire logic [15:0] amb_next = sat16(20'(signed'({4'h0, cur_amb})) + drift);

    // offsets follow drift so the absolute peak level stays put
    wire logic [15:0] uofs_drift = sat16(20'(signed'({4'h0, cur_uofs})) - drift);
    wire logic [15:0] lofs_drift = sat16(20'(signed'({4'h0, cur_lofs})) + drift);

    // average peak tracking when the response reaches the peak fraction gate
    wire logic signed [19:0] neg_resp = 20'(-resp);
    wire logic [23:0] up_scaled = {resp[19:0], 4'h0};
    wire logic [23:0] lo_scaled = {neg_resp[19:0], 4'h0};
    wire logic [23:0] up_gate = 24'(cur_uofs) * 24'(upper_peak_fraction);
    wire logic [23:0] lo_gate = 24'(cur_lofs) * 24'(lower_peak_fraction);
    wire logic up_peak = i_conv.valid && stage_ok && !resp[19] && (resp != 20'sd0)
                       && (up_scaled >= up_gate);
    wire logic lo_peak = i_conv.valid && stage_ok && resp[19]
                       && (lo_scaled >= lo_gate);
    wire logic signed [19:0] up_step = (resp - 20'(signed'({4'h0, cur_uofs})))
                                     >>> atat_pkg::PEAK_SHIFT;
    wire logic signed [19:0] lo_step = (neg_resp - 20'(signed'({4'h0, cur_lofs})))
                                     >>> atat_pkg::PEAK_SHIFT;
    wire logic [15:0] uofs_peak = sat16(20'(signed'({4'h0, cur_uofs})) + up_step);
    wire logic [15:0] lofs_peak = sat16(20'(signed'({4'h0, cur_lofs})) + lo_step);

    wire logic [15:0] conv_uofs = up_peak ? uofs_peak : uofs_drift;
    wire logic [15:0] conv_lofs = lo_peak ? lofs_peak : lofs_drift;

    // ------------------------------------------------------------
    // shared update port: host writes win over the conversion
    // ------------------------------------------------------------
    wire logic sel_ok = (32'(stage_sel_ff) < STAGES);
    wire logic conv_upd = i_conv.valid && stage_ok && !host_upd;
    wire logic upd_en = (host_upd && sel_ok) || conv_upd;
    wire logic [3:0] upd_idx = host_upd ? stage_sel_ff : cs;
    wire logic [15:0] h_amb = sel_ok ? ambient_ff[stage_sel_ff] : 16'h0000;
    wire logic [15:0] h_uofs = sel_ok ? upper_ofs_ff[stage_sel_ff] : 16'h0000;
    wire logic [15:0] h_lofs = sel_ok ? lower_ofs_ff[stage_sel_ff] : 16'h0000;
    wire logic [15:0] upd_amb = !host_upd ? amb_next : (wr_amb ? i_wdata : h_amb);
    wire logic [15:0] upd_uofs = !host_upd ? conv_uofs : (wr_uofs ? i_wdata : h_uofs);
    wire logic [15:0] upd_lofs = !host_upd ? conv_lofs : (wr_lofs ? i_wdata : h_lofs);

    // limits always rebuilt from the values being stored
    wire logic [15:0] upd_ulim = sat16(20'(signed'({4'h0, upd_amb}))
        + 20'(signed'({4'h0, limit_step(upd_uofs, upper_sensitivity_sel)})));
    wire logic [15:0] upd_llim = sat16(20'(signed'({4'h0, upd_amb}))
        - 20'(signed'({4'h0, limit_step(upd_lofs, lower_sensitivity_sel)})));

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            for (int i = 0; i < STAGES; i++) begin
                ambient_ff[i] <= atat_pkg::RST_STAGE_DATA;
                slow_last_ff[i] <= atat_pkg::RST_STAGE_DATA;
                upper_ofs_ff[i] <= atat_pkg::RST_STAGE_DATA;
                lower_ofs_ff[i] <= atat_pkg::RST_STAGE_DATA;
                upper_lim_ff[i] <= atat_pkg::RST_STAGE_DATA;
                lower_lim_ff[i] <= atat_pkg::RST_STAGE_DATA;
            end
        end else begin
            if (upd_en) begin
                ambient_ff[upd_idx] <= upd_amb;
                upper_ofs_ff[upd_idx] <= upd_uofs;
                lower_ofs_ff[upd_idx] <= upd_lofs;
                upper_lim_ff[upd_idx] <= upd_ulim;
                lower_lim_ff[upd_idx] <= upd_llim;
            end
            if (wr_amb && sel_ok) begin
                slow_last_ff[stage_sel_ff] <= i_wdata;
            end else if (admit && !host_upd) begin
                slow_last_ff[cs] <= i_conv.value;
            end
        end
    end

    // ------------------------------------------------------------
    // result output
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_result <= '0;
        end else begin
            o_result.valid <= i_conv.valid;
            o_result.stage <= cs;
            o_result.upper_active <= i_conv.valid && up_act;
            o_result.lower_active <= i_conv.valid && lo_act;
            o_result.admitted <= admit && !host_upd;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (i_addr)
            atat_pkg::ADDR_SKIP_CTRL: rd_mux = skip_ctrl_ff;
            atat_pkg::ADDR_CTRL_ONE: rd_mux = ctrl_one_ff;
            atat_pkg::ADDR_SENS_CFG: rd_mux = sens_cfg_ff;
            atat_pkg::ADDR_MODE_CFG: rd_mux = mode_cfg_ff;
            atat_pkg::ADDR_STAGE_SEL: rd_mux = {12'h000, stage_sel_ff};
            atat_pkg::ADDR_UPPER_OFS: rd_mux = h_uofs;
            atat_pkg::ADDR_LOWER_OFS: rd_mux = h_lofs;
            atat_pkg::ADDR_AMBIENT: rd_mux = h_amb;
            atat_pkg::ADDR_UPPER_LIM: rd_mux = sel_ok ? upper_lim_ff[stage_sel_ff] : 16'h0000;
            atat_pkg::ADDR_LOWER_LIM: rd_mux = sel_ok ? lower_lim_ff[stage_sel_ff] : 16'h0000;
            atat_pkg::ADDR_SLOW_LAST: rd_mux = sel_ok ? slow_last_ff[stage_sel_ff] : 16'h0000;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rdata_ff <= 16'h0000;
        end else if (i_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign o_rdata = rdata_ff;

endmodule : atat_core

// >>> core/atat_pkg.sv
package atat_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SKIP_CTRL = 8'h01;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h03;
    localparam logic [7:0] ADDR_SENS_CFG = 8'h10;
    localparam logic [7:0] ADDR_MODE_CFG = 8'h11;
    localparam logic [7:0] ADDR_STAGE_SEL = 8'h12;
    localparam logic [7:0] ADDR_UPPER_OFS = 8'h13;
    localparam logic [7:0] ADDR_LOWER_OFS = 8'h14;
    localparam logic [7:0] ADDR_AMBIENT = 8'h15;
    localparam logic [7:0] ADDR_UPPER_LIM = 8'h16;
    localparam logic [7:0] ADDR_LOWER_LIM = 8'h17;
    localparam logic [7:0] ADDR_SLOW_LAST = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SKIP_FP_LSB = 12;
    localparam int SKIP_LP_LSB = 14;
    localparam int SENS_STAGES_LSB = 0;
    localparam int SENS_LOWER_SEL_LSB = 4;
    localparam int SENS_UPPER_SEL_LSB = 8;
    localparam int SENS_LOWER_PEAK_LSB = 12;
    localparam int MODE_UPPER_PEAK_LSB = 0;
    localparam int MODE_LOW_POWER_BIT = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_SKIP_CTRL = 16'h0000;
    localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
    localparam logic [15:0] RST_SENS_CFG = 16'h8838;
    localparam logic [15:0] RST_MODE_CFG = 16'h0008;
    localparam logic [15:0] RST_STAGE_DATA = 16'h0000;

    // ------------------------------------------------------------
    // datapath constants
    // ------------------------------------------------------------
    localparam int AMB_SHIFT = 2;
    localparam int PEAK_SHIFT = 2;
    localparam logic [1:0] FP_ZERO_SKIPS = 2'h3;

    typedef struct packed {
        logic valid;
        logic [3:0] stage;
        logic [15:0] value;
    } atat_conv_t;

    typedef struct packed {
        logic valid;
        logic [3:0] stage;
        logic upper_active;
        logic lower_active;
        logic admitted;
    } atat_result_t;

endpackage : atat_pkg

// >>> verification/atat_core_props.sv
`timescale 1ns/1ps
module atat_props #(
    parameter int STAGES = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire atat_pkg::atat_conv_t i_conv,
    input wire atat_pkg::atat_result_t o_result
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // ------------------------------------------------------------
    // skip word write then read
    // ------------------------------------------------------------
    sequence skip_wr_s;
        i_wr && i_addr == atat_pkg::ADDR_SKIP_CTRL;
    endsequence
    sequence skip_rd_s;
        i_rd && i_addr == atat_pkg::ADDR_SKIP_CTRL;
    endsequence
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not idle");
    skip_rdback_a: assert property (skip_wr_s ##1 skip_rd_s |=> o_rdata == $past(i_wdata, 2))
        else $error("skip word readback wrong");
    result_follow_a: assert property (i_conv.valid |=> o_result.valid && o_result.stage == $past(i_conv.stage))
        else $error("result not one cycle after sample");
    result_idle_a: assert property (!i_conv.valid |=> !o_result.valid)
        else $error("result without sample");
    touch_block_a: assert property (o_result.valid && (o_result.upper_active || o_result.lower_active) |-> !o_result.admitted)
        else $error("touched sample admitted");
    flags_apart_a: assert property (o_result.valid |-> !(o_result.upper_active && o_result.lower_active))
        else $error("both limits passed at once");
    bad_stage_a: assert property (i_conv.valid && i_conv.stage >= STAGES |=> !o_result.admitted && !o_result.upper_active)
        else $error("stage out of range acted on");
    host_drop_a: assert property (i_conv.valid && i_wr && i_addr inside {8'h13, 8'h14, 8'h15} |=> !o_result.admitted)
        else $error("admitted during host write");
endmodule : atat_props
bind atat_core atat_props #(.STAGES(STAGES)) i_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_conv(i_conv), .o_result(o_result));

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic i_clk_sys, i_sys_rst, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata, amb, uo, lo, w, v;
    atat_pkg::atat_conv_t i_conv;
    atat_pkg::atat_result_t o_result, res;
    int error_cnt, comparisons, seed, adm, n, ex;
    atat_core #(.STAGES(12)) i_dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_conv(i_conv),
        .o_result(o_result));
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    // ------------------------------------------------------------
    // compare, report, bus tasks
    // ------------------------------------------------------------
    task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task chk_res(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_res
    task results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // strobe left high; the next task lowers it, so back-to-back writes never toggle it
    task wr(input logic [7:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
    endtask : wr
    task rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        i_wr <= 1'b0;
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk_word(nm, e, o_rdata);
        @(posedge i_clk_sys);
    endtask : rd
    task conv(input logic [3:0] s, input logic [15:0] val);
        i_wr <= 1'b0;
        i_conv <= '{1'b1, s, val};
        @(posedge i_clk_sys);
        i_conv.valid <= 1'b0;
        @(negedge i_clk_sys);
        res = o_result;
        @(posedge i_clk_sys);
    endtask : conv
    function logic [15:0] step(input logic [15:0] o, input logic [3:0] sel);
        logic [15:0] q;
        q = o >> 2;
        return q + 16'((32'(o - q) * 32'(sel)) >> 4);
    endfunction : step
    // limits clamp to the converter range
    function logic [15:0] lim(input int a, input int st);
        int t;
        t = a + st;
        if (t < 0) t = 0;
        if (t > 65535) t = 65535;
        return 16'(t);
    endfunction : lim
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        error_cnt++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 66;
        error_cnt = 0;
        comparisons = 0;
        i_sys_rst = 1'b1;
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        i_conv = '0;
        repeat (8) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        @(posedge i_clk_sys);
        rd(atat_pkg::ADDR_SKIP_CTRL, atat_pkg::RST_SKIP_CTRL, "skip reset");
        rd(atat_pkg::ADDR_CTRL_ONE, atat_pkg::RST_CTRL_ONE, "level reset");
        rd(atat_pkg::ADDR_SENS_CFG, atat_pkg::RST_SENS_CFG, "sens reset");
        rd(8'h40, 16'h0000, "unmapped");
        wr(atat_pkg::ADDR_STAGE_SEL, 16'h0002);
        for (int k = 0; k < 16; k++) begin
            {uo, lo, amb} = 48'({$random(seed), $random(seed)});
            wr(atat_pkg::ADDR_SENS_CFG, {4'h8, 4'(k), 4'(15 - k), 4'hb});
            wr(atat_pkg::ADDR_AMBIENT, amb);
            wr(atat_pkg::ADDR_UPPER_OFS, uo);
            wr(atat_pkg::ADDR_LOWER_OFS, lo);
            wr(atat_pkg::ADDR_UPPER_LIM, ~uo);
            rd(atat_pkg::ADDR_UPPER_LIM, lim(amb, step(uo, 4'(k))), "upper limit");
            rd(atat_pkg::ADDR_LOWER_LIM, lim(amb, -int'(step(lo, 4'(15 - k)))), "lower limit");
        end
        wr(atat_pkg::ADDR_SENS_CFG, 16'h8832);
        wr(atat_pkg::ADDR_SKIP_CTRL, 16'h1000);
        wr(atat_pkg::ADDR_CTRL_ONE, 16'h0010);
        wr(atat_pkg::ADDR_AMBIENT, 16'h4000);
        wr(atat_pkg::ADDR_UPPER_OFS, 16'h2000);
        wr(atat_pkg::ADDR_LOWER_OFS, 16'h2000);
        conv(4'h2, 16'h4010);
        chk_res("equal level", 8'h90, res);
        conv(4'h2, 16'h4011);
        chk_res("admit", 8'h91, res);
        amb = 16'h4004;
        uo = 16'h1ffc;
        lo = 16'h2004;
        rd(atat_pkg::ADDR_AMBIENT, amb, "ambient");
        rd(atat_pkg::ADDR_UPPER_OFS, uo, "upper ofs drift");
        rd(atat_pkg::ADDR_LOWER_OFS, lo, "lower ofs drift");
        rd(atat_pkg::ADDR_SLOW_LAST, 16'h4011, "last");
        rd(atat_pkg::ADDR_UPPER_LIM, lim(amb, step(uo, 4'h8)), "upper relimit");
        rd(atat_pkg::ADDR_LOWER_LIM, lim(amb, -int'(step(lo, 4'h3))), "lower relimit");
        conv(4'h2, amb + uo + 16'h0100);
        chk_res("touch up", 8'h94, res);
        uo = uo + 16'h0040;
        rd(atat_pkg::ADDR_AMBIENT, amb, "ambient held");
        rd(atat_pkg::ADDR_UPPER_OFS, uo, "max average");
        rd(atat_pkg::ADDR_UPPER_LIM, lim(amb, step(uo, 4'h8)), "rescale");
        conv(4'h2, amb - lo - 16'h0100);
        chk_res("touch down", 8'h92, res);
        rd(atat_pkg::ADDR_LOWER_OFS, lo + 16'h0040, "min average");
        i_conv <= '{1'b1, 4'h2, amb + 16'h0080};
        wr(atat_pkg::ADDR_UPPER_OFS, uo);
        i_conv.valid <= 1'b0;
        i_wr <= 1'b0;
        @(negedge i_clk_sys);
        chk_res("host clash", 8'h90, o_result);
        @(posedge i_clk_sys);
        rd(atat_pkg::ADDR_AMBIENT, amb, "clash ambient");
        conv(4'hd, 16'hffff);
        chk_res("bad stage", 8'he8, res);
        wr(atat_pkg::ADDR_SENS_CFG, 16'h8830);
        wr(atat_pkg::ADDR_STAGE_SEL, 16'h0000);
        // stages field 0 makes each stage-0 conversion a whole sequence; 12 sequences suit every skip period
        for (int c = 0; c < 8; c++) begin
            n = c % 4;
            w = 16'($random(seed)) & 16'h0fff;
            w = (c < 4) ? (w | 16'(n << 12)) : (w | 16'(n << 14));
            ex = (c < 4) ? ((n == 0) ? 3 : 12 / n) : 12 / (n + 1);
            wr(atat_pkg::ADDR_MODE_CFG, (c < 4) ? 16'h0008 : 16'h0018);
            wr(atat_pkg::ADDR_SKIP_CTRL, w);
            rd(atat_pkg::ADDR_SKIP_CTRL, w, "skip word");
            wr(atat_pkg::ADDR_AMBIENT, 16'h1000);
            wr(atat_pkg::ADDR_UPPER_OFS, 16'h4000);
            wr(atat_pkg::ADDR_LOWER_OFS, 16'h4000);
            adm = 0;
            for (int j = 1; j <= 12; j++) begin
                conv(4'h0, 16'(16'h1000 + j * 64));
                adm += int'(res.admitted);
            end
            chk_word("admits", 16'(ex), 16'(adm));
        end
        results();
    end
endmodule : tb
